// ---- hdl/e1sc_clr_latch.sv ----
// Bank of sticky status bits cleared by a register read.
// Assumes set pulses and the read strobe share the block clock.
`timescale 1ns/1ps
`default_nettype none
module e1sc_clr_latch #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_set,
  input wire logic i_rd_clr,
  output logic [W-1:0] o_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_q <= '0;
    end else begin
      o_q <= i_set | (i_rd_clr ? '0 : o_q);
    end
  end

  AST_SET_OVER_CLR: assert property (i_rd_clr |=> ((o_q & $past(i_set)) == $past(i_set)))
    else $error("event lost on clearing read");
  AST_HOLD: assert property (!i_rd_clr && (i_set == '0) |=> $stable(o_q))
    else $error("sticky bit changed without cause");
endmodule : e1sc_clr_latch
`default_nettype wire

// ---- hdl/e1sc_fifo.sv ----
// Synchronous FIFO with a registered output word.
// Assumes DEPTH is a power of two and a single clock.
`timescale 1ns/1ps
`default_nettype none
module e1sc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  e1sc_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic load;

  // Output stage refills when empty or consumed
  assign push = f.wr_valid && f.wr_ready;
  assign load = (cnt_r != '0) && (!f.rd_valid || f.rd_ready);
  assign f.wr_ready = (cnt_r != FULL_CNT);

  // Storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= f.wr_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (load) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end

  // Registered head word, so the top sees flop outputs
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      f.rd_valid <= 1'b0;
      f.rd_data <= '0;
    end else if (load) begin
      f.rd_valid <= 1'b1;
      f.rd_data <= mem[rp_r];
    end else if (f.rd_ready) begin
      f.rd_valid <= 1'b0;
    end
  end
endmodule : e1sc_fifo
`default_nettype wire

// ---- hdl/e1sc_fifo_if.sv ----
// Handshake bundle between the TS16 byte builder and its FIFO.
// Assumes one clock; the user of the bundle supplies it.
`timescale 1ns/1ps
`default_nettype none
interface e1sc_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport src(output wr_valid, output wr_data, input wr_ready);
  modport fifo(input wr_valid, input wr_data, input rd_ready,
               output wr_ready, output rd_valid, output rd_data);
  modport snk(input rd_valid, input rd_data, output rd_ready);
endinterface : e1sc_fifo_if
`default_nettype wire

// ---- hdl/e1sc_pkg.sv ----
// Constants shared by the E1 status / transmit CAS register block.
// Assumes page and address come from the framer's parallel port logic.
package e1sc_pkg;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  localparam int ADDR_W = 5;
  localparam int SLOT_W = 5;
  localparam int FRAME_W = 4;
  localparam int CHANS = 32;
  localparam int FRAMES = 16;
  localparam int FIFO_DEPTH = 16;
  // Pages
  localparam logic [3:0] PG_STATUS = 4'h4;
  localparam logic [3:0] PG_TXCAS_LO = 4'h5;
  localparam logic [3:0] PG_TXCAS_HI = 4'h6;
  localparam logic [3:0] PG_TSCTL_LO = 4'h7;
  localparam logic [3:0] PG_TSCTL_HI = 4'h8;
  // Addresses within a page
  localparam logic [4:0] ADDR_IRQ3 = 5'h1E;
  localparam logic [4:0] ADDR_OVFL = 5'h1F;
  localparam logic [4:0] ADDR_CHAN_BASE = 5'h10;
  // Interrupt word three bit positions
  localparam int B_FIRST_LINK = 6;
  localparam int B_SECOND_LINK = 5;
  localparam int B_JITTER = 4;
  localparam int B_ONE_SEC = 3;
  localparam int B_FIVE_SEC = 2;
  localparam int B_REM_CRC = 1;
  localparam int B_SIG_CHG = 0;
  // Overflow latch bit positions
  localparam int B_FRAME_ERR_OVF = 7;
  localparam int B_CRC_OVF = 6;
  localparam int B_FEBE_OVF = 5;
  localparam int B_BPV_OVF = 3;
  localparam int B_PATT_OVF = 2;
  localparam int B_PATT_MF_OVF = 1;
  // Per time slot control word field
  localparam int B_REG_SIG_SEL = 1;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [3:0] RST_CAS = 4'h0;
  localparam logic [7:0] RST_SER = 8'h00;
endpackage : e1sc_pkg

// ---- hdl/e1sc_top.sv ----
// E1 interrupt word three, counter overflow latch and transmit CAS source.
// Assumes register strobes, event inputs and the control stream all come
// from framer logic on i_clk, so no synchronisers are placed on them.
`timescale 1ns/1ps
`default_nettype none
module e1sc_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [e1sc_pkg::PAGE_W-1:0] i_page,
  input wire logic [e1sc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [e1sc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [e1sc_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  input wire logic [e1sc_pkg::DATA_W-1:0] i_irq3_mask,
  input wire logic i_first_link_ctrl_irq,
  input wire logic i_second_link_ctrl_irq,
  input wire logic i_jitter_fifo_margin,
  input wire logic i_one_second_status,
  input wire logic i_five_second_status,
  input wire logic i_remote_alarm,
  input wire logic i_crc_error,
  input wire logic i_signaling_change,
  input wire logic i_frame_align_err_ovf,
  input wire logic i_crc_err_ovf,
  input wire logic i_far_end_block_err_ovf,
  input wire logic i_bipolar_violation_ovf,
  input wire logic i_test_pattern_err_ovf,
  input wire logic i_test_pattern_multiframe_ovf,
  input wire logic i_signaling_nibble_select,
  input wire logic i_ser_valid,
  input wire logic [e1sc_pkg::SLOT_W-1:0] i_ser_slot,
  input wire logic [e1sc_pkg::DATA_W-1:0] i_ser_byte,
  input wire logic i_ts16_req,
  input wire logic [e1sc_pkg::FRAME_W-1:0] i_ts16_frame,
  output logic o_ts16_busy,
  output logic o_ts16_valid,
  output logic [e1sc_pkg::DATA_W-1:0] o_ts16_data,
  input wire logic i_ts16_ready
);
  import e1sc_pkg::*;

  logic [DATA_W-1:0] irq3_set;
  logic [DATA_W-1:0] irq3_q;
  logic [DATA_W-1:0] ovf_set;
  logic [DATA_W-1:0] ovf_q;
  logic sec1_d_r;
  logic sec5_d_r;
  logic [3:0] cas_r [CHANS];
  logic [CHANS-1:0] regsig_r;
  logic [DATA_W-1:0] ser_r [FRAMES];
  logic sel_irq3;
  logic sel_ovfl;
  logic chan_area;
  logic cas_sel;
  logic ctl_sel;
  logic [4:0] chan_idx;
  logic ser_hit;
  logic pend_r;
  logic [FRAME_W-1:0] pend_frame_r;
  logic [3:0] nib_hi;
  logic [3:0] nib_lo;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_r;
  logic rvalid_r;

  e1sc_fifo_if #(.W(DATA_W)) fif ();

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Register decode for the paged parallel port
  assign sel_irq3 = (i_page == PG_STATUS) && (i_addr == ADDR_IRQ3);
  assign sel_ovfl = (i_page == PG_STATUS) && (i_addr == ADDR_OVFL);
  assign chan_area = (i_addr >= ADDR_CHAN_BASE);
  assign cas_sel = chan_area &&
                   ((i_page == PG_TXCAS_LO) || (i_page == PG_TXCAS_HI));
  assign ctl_sel = chan_area &&
                   ((i_page == PG_TSCTL_LO) || (i_page == PG_TSCTL_HI));
  assign chan_idx = {(i_page == PG_TXCAS_HI) || (i_page == PG_TSCTL_HI),
                     i_addr[3:0]};

  // Previous status levels for rising edge detection
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sec1_d_r <= 1'b0;
      sec5_d_r <= 1'b0;
    end else begin
      sec1_d_r <= i_one_second_status;
      sec5_d_r <= i_five_second_status;
    end
  end

  // Event sources of word three, gated by the mask (1 = unmasked)
  always_comb begin
    irq3_set = '0;
    irq3_set[B_FIRST_LINK] = i_first_link_ctrl_irq;
    irq3_set[B_SECOND_LINK] = i_second_link_ctrl_irq;
    irq3_set[B_JITTER] = i_jitter_fifo_margin;
    irq3_set[B_ONE_SEC] = i_one_second_status && !sec1_d_r;
    irq3_set[B_FIVE_SEC] = i_five_second_status && !sec5_d_r;
    irq3_set[B_REM_CRC] = i_remote_alarm && i_crc_error;
    // signaling change, debounced upstream if enabled
    irq3_set[B_SIG_CHG] = i_signaling_change;
    irq3_set = irq3_set & i_irq3_mask;
  end

  // Counter overflow pulses; unused bits 4 and 0 stay zero
  always_comb begin
    ovf_set = '0;
    ovf_set[B_FRAME_ERR_OVF] = i_frame_align_err_ovf;
    ovf_set[B_CRC_OVF] = i_crc_err_ovf;
    ovf_set[B_FEBE_OVF] = i_far_end_block_err_ovf;
    ovf_set[B_BPV_OVF] = i_bipolar_violation_ovf;
    ovf_set[B_PATT_OVF] = i_test_pattern_err_ovf;
    ovf_set[B_PATT_MF_OVF] = i_test_pattern_multiframe_ovf;
  end

  e1sc_clr_latch #(.W(DATA_W)) u_irq3 (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_set(irq3_set),
    .i_rd_clr(i_rd && sel_irq3),
    .o_q(irq3_q)
  );

  e1sc_clr_latch #(.W(DATA_W)) u_ovf (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_set(ovf_set),
    .i_rd_clr(i_rd && sel_ovfl),
    .o_q(ovf_q)
  );

  // Per channel CAS nibbles and register select bits
  for (genvar g = 0; g < CHANS; g++) begin : g_chan
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        cas_r[g] <= RST_CAS;
      end else if (i_wr && cas_sel && (chan_idx == 5'(g))) begin
        cas_r[g] <= i_wdata[3:0];
      end
    end
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        regsig_r[g] <= 1'b0;
      end else if (i_wr && ctl_sel && (chan_idx == 5'(g))) begin
        regsig_r[g] <= i_wdata[B_REG_SIG_SEL];
      end
    end
  end

  assign ser_hit = i_ser_valid && (i_ser_slot[4] == i_signaling_nibble_select)
                   && (i_ser_slot[3:0] != 4'h0);

  // Control stream bytes, one per frame; slot 0 and 16 never carry CAS
  for (genvar f = 0; f < FRAMES; f++) begin : g_ser
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        ser_r[f] <= RST_SER;
      end else if (ser_hit && (i_ser_slot[3:0] == 4'(f))) begin
        ser_r[f] <= i_ser_byte;
      end
    end
  end

  // Pending TS16 request; busy stalls the requester while FIFO is full
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pend_r <= 1'b0;
      pend_frame_r <= '0;
    end else if (!pend_r) begin
      if (i_ts16_req && (i_ts16_frame != '0)) begin
        pend_r <= 1'b1;
        pend_frame_r <= i_ts16_frame;
      end
    end else if (fif.wr_ready) begin
      pend_r <= 1'b0;
    end
  end

  assign nib_hi = regsig_r[{1'b0, pend_frame_r}] ?
                  cas_r[{1'b0, pend_frame_r}] : ser_r[pend_frame_r][7:4];
  assign nib_lo = regsig_r[{1'b1, pend_frame_r}] ?
                  cas_r[{1'b1, pend_frame_r}] : ser_r[pend_frame_r][3:0];
  // ABCD of the low channel goes first on the line (bits 1-4)
  assign fif.wr_valid = pend_r;
  assign fif.wr_data = {nib_hi, nib_lo};
  assign fif.rd_ready = i_ts16_ready;

  e1sc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .f(fif)
  );

  // Read data mux; unmapped locations read zero
  always_comb begin
    rd_mux = '0;
    if (sel_irq3) rd_mux = irq3_q;
    else if (sel_ovfl) rd_mux = ovf_q;
    else if (cas_sel) rd_mux = {4'h0, cas_r[chan_idx]};
    else if (ctl_sel) rd_mux[B_REG_SIG_SEL] = regsig_r[chan_idx];
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_rd;
      if (i_rd) rdata_r <= rd_mux;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_ts16_busy = pend_r;
  assign o_ts16_valid = fif.rd_valid;
  assign o_ts16_data = fif.rd_data;

  sequence seq_rd_irq3;
    i_rd && sel_irq3 && (irq3_set == '0);
  endsequence
  sequence seq_rd_ovf;
    i_rd && sel_ovfl && (ovf_set == '0);
  endsequence
  sequence seq_cas_wr_hi;
    i_wr && cas_sel && (i_page == PG_TXCAS_HI);
  endsequence

  AST_FIRST_LINK: assert property (i_first_link_ctrl_irq && i_irq3_mask[6] |=> irq3_q[6])
    else $error("bit 6 of word three not set");
  AST_IRQ3_CLR: assert property (seq_rd_irq3 |=> irq3_q == 8'h00 && o_rdata == $past(irq3_q))
    else $error("word three not cleared by read");
  AST_SECOND_LINK: assert property (i_second_link_ctrl_irq && i_irq3_mask[5] |=> irq3_q[5])
    else $error("bit 5 of word three not set");
  AST_JITTER: assert property (i_jitter_fifo_margin && i_irq3_mask[4] |=> irq3_q[4])
    else $error("bit 4 of word three not set");
  AST_ONE_SEC: assert property ($rose(i_one_second_status) && i_irq3_mask[3] |=> irq3_q[3])
    else $error("bit 3 not set on one second rise");
  AST_FIVE_SEC: assert property ($rose(i_five_second_status) && i_irq3_mask[2] |=> irq3_q[2])
    else $error("bit 2 not set on five second rise");
  AST_REM_CRC: assert property (!(i_remote_alarm && i_crc_error) && !irq3_q[1] |=> !irq3_q[1])
    else $error("bit 1 set without alarm and CRC error");
  AST_SIG: assert property (i_signaling_change && i_irq3_mask[0] |=> irq3_q[0])
    else $error("bit 0 not set on signaling change");
  AST_FRAME_OVF: assert property (i_frame_align_err_ovf |=> ovf_q[7] until (i_rd && sel_ovfl))
    else $error("overflow bit 7 dropped before read");
  AST_OVF_CLR: assert property (seq_rd_ovf |=> ovf_q == 8'h00)
    else $error("overflow latch not cleared by read");
  AST_CRC_OVF: assert property (i_crc_err_ovf |=> ovf_q[6])
    else $error("overflow bit 6 not set");
  AST_FEBE_OVF: assert property (i_far_end_block_err_ovf |=> ovf_q[5])
    else $error("overflow bit 5 not set");
  AST_BPV_OVF: assert property (i_bipolar_violation_ovf |=> ovf_q[3] && !ovf_q[4])
    else $error("overflow bit 3 wrong");
  AST_PATT_OVF: assert property (i_test_pattern_err_ovf |=> ovf_q[2] && !ovf_q[0])
    else $error("overflow bit 2 wrong");
  AST_PATT_MF_OVF: assert property (i_test_pattern_multiframe_ovf |=> ovf_q[1])
    else $error("overflow bit 1 not set");
  AST_REG_SRC: assert property (pend_r && regsig_r[{1'b0, pend_frame_r}] |-> fif.wr_data[7:4] == cas_r[{1'b0, pend_frame_r}])
    else $error("register CAS not used");
  AST_PAGE_MAP: assert property (seq_cas_wr_hi |=> cas_r[{1'b1, $past(i_addr[3:0])}] == $past(i_wdata[3:0]))
    else $error("high page not mapped to channels 17-32");
  AST_CAS_RD: assert property (i_rd && cas_sel |=> o_rvalid && o_rdata[7:4] == 4'h0)
    else $error("CAS word upper nibble not zero");
  AST_SER_SRC: assert property (pend_r && !regsig_r[{1'b1, pend_frame_r}] |-> fif.wr_data[3:0] == ser_r[pend_frame_r][3:0])
    else $error("stream CAS not used");
  AST_SLOT_WIN: assert property (ser_hit |=> ser_r[$past(i_ser_slot[3:0])] == $past(i_ser_byte))
    else $error("selected stream slot not captured");
  AST_CTL_BIT: assert property (i_wr && ctl_sel |=> regsig_r[$past(chan_idx)] == $past(i_wdata[1]))
    else $error("register select bit not stored");
endmodule : e1sc_top
`default_nettype wire

// ---- tb/e1sc_host.sv ----
// Host processor model driving the block's parallel register port.
// Assumes strobes sampled on rising i_clk and rvalid one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module e1sc_host (
  input wire logic i_clk,
  input wire logic [e1sc_pkg::DATA_W-1:0] i_rdata,
  input wire logic i_rvalid,
  output logic [e1sc_pkg::PAGE_W-1:0] o_page,
  output logic [e1sc_pkg::ADDR_W-1:0] o_addr,
  output logic [e1sc_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  import e1sc_pkg::*;
  // Idle port at time zero
  initial begin
    o_page = 4'h0;
    o_addr = 5'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One write; data inverted on release so stale values never match
  task automatic wr_reg(input logic [3:0] pg, input logic [4:0] ad,
                        input logic [7:0] d);
    @(posedge i_clk) #1;
    o_page = pg;
    o_addr = ad;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk) #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask : wr_reg
  // One read; answer taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] pg, input logic [4:0] ad,
                        output logic [7:0] d, output logic v);
    @(posedge i_clk) #1;
    o_page = pg;
    o_addr = ad;
    o_rd = 1'b1;
    @(posedge i_clk) #1;
    o_rd = 1'b0;
    v = i_rvalid;
    d = i_rdata;
  endtask : rd_reg
endmodule : e1sc_host
`default_nettype wire

// ---- tb/test_e1_status_and_cas_transmit.sv ----
// Self-checking bench for the E1 status and transmit CAS block.
// Assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module test_e1_status_and_cas_transmit;
  import e1sc_pkg::*;
  logic i_clk, i_nrst, wr, rd, rvalid, ns, sv, req, busy, tv, rdy, rdy_en;
  logic [3:0] page, frame;
  logic [4:0] addr, slot;
  logic [7:0] wdata, rdata, mask, ev, ov, sbyte, tdata;
  logic [31:0] seed, rseed;
  logic [3:0] cas [32];
  logic sel [32];
  logic [7:0] str [16];
  logic [7:0] q [$];
  int fail_count, num_checks;
  int ovp [6] = '{7, 6, 5, 3, 2, 1};

  e1sc_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_page(page), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  e1sc_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_page(page),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_irq3_mask(mask),
    .i_first_link_ctrl_irq(ev[6]), .i_second_link_ctrl_irq(ev[5]),
    .i_jitter_fifo_margin(ev[4]), .i_one_second_status(ev[3]),
    .i_five_second_status(ev[2]), .i_remote_alarm(ev[1]),
    .i_crc_error(ev[7]), .i_signaling_change(ev[0]),
    .i_frame_align_err_ovf(ov[7]), .i_crc_err_ovf(ov[6]),
    .i_far_end_block_err_ovf(ov[5]), .i_bipolar_violation_ovf(ov[3]),
    .i_test_pattern_err_ovf(ov[2]), .i_test_pattern_multiframe_ovf(ov[1]),
    .i_signaling_nibble_select(ns), .i_ser_valid(sv), .i_ser_slot(slot),
    .i_ser_byte(sbyte), .i_ts16_req(req), .i_ts16_frame(frame),
    .o_ts16_busy(busy), .o_ts16_valid(tv), .o_ts16_data(tdata),
    .i_ts16_ready(rdy));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected TS16 byte: register nibble or stream nibble per slot
  function automatic logic [7:0] exp_ts16(input int n);
    logic [3:0] hi, lo;
    hi = sel[n] ? cas[n] : str[n][7:4];
    lo = sel[n + 16] ? cas[n + 16] : str[n][3:0];
    return {hi, lo};
  endfunction : exp_ts16
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [3:0] pg, input logic [4:0] ad,
                       input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd_reg(pg, ad, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask : rdchk
  // One-cycle pulse on event and overflow inputs
  task automatic pulse(input logic [7:0] e3, input logic [7:0] o);
    @(posedge i_clk) #1;
    ev = e3;
    ov = o;
    @(posedge i_clk) #1;
    ev = 8'h00;
    ov = 8'h00;
  endtask : pulse
  // Request waits out busy, bounded so a hang reaches the watchdog
  task automatic ask(input logic [3:0] f);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge i_clk) #1;
      n++;
    end
    @(posedge i_clk) #1;
    req = 1'b1;
    frame = f;
    @(posedge i_clk) #1;
    req = 1'b0;
    frame = ~f;
    if (f != 4'h0) q.push_back(exp_ts16(f));
    if (f == 4'h0) chk({7'h00, busy}, 8'h00);
  endtask : ask
  task automatic drain;
    int n;
    n = 0;
    while (q.size() > 0 && n < 3000) begin
      @(posedge i_clk) #1;
      n++;
    end
    chk(8'(q.size()), 8'h00);
  endtask : drain
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Consumer stalls at random so the FIFO sees back pressure
  always @(posedge i_clk) begin
    #1;
    rseed = lfsr(rseed);
    rdy = rdy_en & rseed[5];
  end
  // Popped bytes checked where settled, before the popping edge
  always @(negedge i_clk) begin
    if (tv === 1'b1 && rdy === 1'b1) begin
      chk(tdata, (q.size() > 0) ? q.pop_front() : ~tdata);
    end
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    fail_count++;
    final_report();
  end

  initial begin
    {i_nrst, ns, sv, req, rdy, rdy_en, ev, ov, slot, sbyte, frame} = '0;
    mask = 8'hFF;
    seed = 32'hEAA5;
    rseed = 32'hEAA5;
    fail_count = 0;
    num_checks = 0;
    foreach (str[i]) str[i] = 8'h00;
    repeat (12) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    rdchk(PG_STATUS, ADDR_IRQ3, 8'h00);
    rdchk(4'h4, 5'h00, 8'h00);
    // Each word three source: set, cleared by read, then masked off
    for (int b = 0; b < 7; b++) begin
      pulse((b == 1) ? 8'h82 : 8'h01 << b, 8'h00);
      rdchk(PG_STATUS, ADDR_IRQ3, 8'h01 << b);
      rdchk(PG_STATUS, ADDR_IRQ3, 8'h00);
      mask = ~(8'h01 << b);
      pulse((b == 1) ? 8'h82 : 8'h01 << b, 8'h00);
      rdchk(PG_STATUS, ADDR_IRQ3, 8'h00);
      mask = 8'hFF;
    end
    pulse(8'h02, 8'h00);
    pulse(8'h80, 8'h00);
    rdchk(PG_STATUS, ADDR_IRQ3, 8'h00);
    // Held level gives one rise only
    ev = 8'h08;
    rdchk(PG_STATUS, ADDR_IRQ3, 8'h08);
    rdchk(PG_STATUS, ADDR_IRQ3, 8'h00);
    ev = 8'h00;
    pulse(8'hFF, 8'hFF);
    host.wr_reg(PG_STATUS, ADDR_IRQ3, 8'h00);
    rdchk(PG_STATUS, ADDR_IRQ3, 8'h7F);
    rdchk(PG_STATUS, ADDR_OVFL, 8'hEE);
    foreach (ovp[i]) begin
      pulse(8'h00, 8'h01 << ovp[i]);
      rdchk(PG_STATUS, ADDR_OVFL, 8'h01 << ovp[i]);
      rdchk(PG_STATUS, ADDR_OVFL, 8'h00);
    end
    // Event landing on the clearing read survives it
    fork
      rdchk(PG_STATUS, ADDR_OVFL, 8'h00);
      begin
        @(posedge i_clk) #1;
        ov = 8'h40;
        @(posedge i_clk) #1;
        ov = 8'h00;
      end
    join
    rdchk(PG_STATUS, ADDR_OVFL, 8'h40);
    // Random CAS words, selects and stream, both nibble halves
    for (int s = 0; s < 2; s++) begin
      ns = s[0];
      for (int k = 0; k < 32; k++) begin
        seed = lfsr(seed);
        cas[k] = seed[3:0];
        sel[k] = seed[9];
        host.wr_reg((k < 16) ? PG_TXCAS_LO : PG_TXCAS_HI,
                    ADDR_CHAN_BASE | {1'b0, k[3:0]}, seed[7:0]);
        host.wr_reg((k < 16) ? PG_TSCTL_LO : PG_TSCTL_HI,
                    ADDR_CHAN_BASE | {1'b0, k[3:0]}, seed[15:8]);
        rdchk((k < 16) ? PG_TXCAS_LO : PG_TXCAS_HI,
              ADDR_CHAN_BASE | {1'b0, k[3:0]}, {4'h0, cas[k]});
        rdchk((k < 16) ? PG_TSCTL_LO : PG_TSCTL_HI,
              ADDR_CHAN_BASE | {1'b0, k[3:0]}, {6'h00, sel[k], 1'b0});
      end
      for (int t = 0; t < 32; t++) begin
        seed = lfsr(seed);
        @(posedge i_clk) #1;
        {sv, slot, sbyte} = {1'b1, t[4:0], seed[7:0]};
        if (t[4] == s[0] && t[3:0] != 4'h0) str[t[3:0]] = seed[7:0];
      end
      @(posedge i_clk) #1;
      sv = 1'b0;
      rdy_en = 1'b1;
      for (int f = 0; f < 16; f++) ask(f[3:0]);
      drain();
    end
    // Fill FIFO and output word with consumer stalled, then drain
    rdy_en = 1'b0;
    for (int i = 0; i < 18; i++) begin
      seed = lfsr(seed);
      ask(4'h1 + (seed[3:0] % 4'hF));
    end
    repeat (5) @(posedge i_clk) #1;
    chk({6'h00, busy, tv}, 8'h03);
    rdy_en = 1'b1;
    drain();
    final_report();
  end
endmodule : test_e1_status_and_cas_transmit
`default_nettype wire
